// ==== hdl/hws_halt_wakeup.sv ====
/*
 * Halt wake-up sequencer: leaves the halt state on a watchdog time-out or a
 * port pin change, or asks for a full system reset on the reset or debug pin.
 * Assumes all inputs are synchronous to ref_clk and a simple strobe bus.
 */
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module hws_halt_wakeup
	import hws_pkg::*;
#(
	parameter int RECOVERY_CYCLES = RECOVERY_CYC
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdata,
	// Watchdog and core
	input  wire logic              wdtTimeout,
	input  wire logic              wdtIntMode,
	input  wire logic              intEnable,
	input  wire logic              wdtIrqAck,
	output logic                   wdtIrqReq,
	output logic                   halted,
	output logic                   sysRstReq,
	output logic                   irq,
	// Pins
	input  wire logic [PIN_W-1:0]  portPins,
	input  wire logic              extRst_n,
	input  wire logic              dbgPin
);

	// Counters run from zero, so each limit is its cycle count less one.
	localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVERY_CYCLES - 1);
	localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(MIN_WAKE_CYC - 1);
	localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(SYSRST_CYC - 1);

	hws_regs_t r;
	hws_regs_t n;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Write-one-to-clear where a same-cycle set wins over the clear.
	function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] clr,
		input logic [3:0] set);
		w1c = (cur & ~clr) | set;
	endfunction

	function automatic logic inHalt(input hws_state_t s);
		inHalt = (s == ST_HALT) || (s == ST_FILTER) || (s == ST_RECOVER);
	endfunction

	logic             wrHit;
	logic [PIN_W-1:0] pinChg;
	logic             resetPin;
	assign wrHit    = regWr;
	assign pinChg   = (portPins ^ r.lastPins) & r.wakeEn;
	assign resetPin = !extRst_n || !dbgPin;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] causeSet;
		logic [3:0] causeClr;
		logic [3:0] evSet;
		logic [3:0] evClr;
		causeSet = '0;
		causeClr = '0;
		evSet    = '0;
		evClr    = '0;
		n        = r;
		n.rdata  = '0;

		if (wrHit && regAddr == OFS_WAKE_EN) begin
			n.wakeEn = regWdata;
		end
		if (wrHit && regAddr == OFS_MASK) begin
			n.mask = regWdata[3:0];
		end
		if (wrHit && regAddr == OFS_CAUSE) begin
			causeClr = regWdata[3:0];
		end
		if (wrHit && regAddr == OFS_STAT) begin
			evClr = regWdata[3:0];
		end
		if (wdtIrqAck) begin
			n.wdtIrq = 1'b0;
		end

		case (r.state)
			ST_RUN: begin
				n.portIn = portPins;
				if (resetPin) begin
					n.state = ST_SYSRST;
					n.cnt   = '0;
					causeSet[CAUSE_EXT] = !extRst_n;
					causeSet[CAUSE_DBG] = !dbgPin;
				end else if (wrHit && regAddr == OFS_CTRL && regWdata[CTRL_HALT_BIT]) begin
					n.state    = ST_HALT;
					n.lastPins = portPins;
					n.wdtPend  = 1'b0;
				end
			end
			// The filter compares with the levels captured at halt entry, so a pulse that
			// returns before the minimum width sends the machine back to waiting.
			ST_HALT, ST_FILTER: begin
				if (resetPin) begin
					n.state = ST_SYSRST;
					n.cnt   = '0;
					causeSet[CAUSE_EXT] = !extRst_n;
					causeSet[CAUSE_DBG] = !dbgPin;
				end else if (wdtTimeout) begin
					n.state   = ST_RECOVER;
					n.cnt     = '0;
					n.wdtPend = wdtIntMode;
					causeSet[CAUSE_WDOG] = 1'b1;
					causeSet[CAUSE_HALT] = 1'b1;
					evSet[EV_WDOG]       = 1'b1;
				end else if (r.state == ST_HALT) begin
					// Pins without a wake enable never leave the halt state.
					if (pinChg != '0) begin
						n.state   = ST_FILTER;
						n.cnt     = '0;
						n.chgPins = pinChg;
					end
				end else if (((portPins ^ r.lastPins) & r.chgPins) == '0) begin
					n.state = ST_HALT;
					causeSet[CAUSE_HALT] = 1'b1;
					evSet[EV_SHORT]      = 1'b1;
				end else if (r.cnt == MIN_LAST) begin
					n.state = ST_RECOVER;
					n.cnt   = '0;
				end else begin
					n.cnt = r.cnt + 1'b1;
				end
			end
			ST_RECOVER: begin
				if (resetPin) begin
					n.state = ST_SYSRST;
					n.cnt   = '0;
					causeSet[CAUSE_EXT] = !extRst_n;
					causeSet[CAUSE_DBG] = !dbgPin;
				end else if (r.cnt == REC_LAST) begin
					n.state  = ST_RUN;
					// Port data load here and in the run state only, so a pin that went back during the
					// delay is never seen by software.
					n.portIn = portPins;
					causeSet[CAUSE_HALT] = 1'b1;
					evSet[EV_RECOVERED]  = 1'b1;
					if (r.wdtPend && intEnable) begin
						n.wdtIrq = 1'b1;
					end
					n.wdtPend = 1'b0;
				end else begin
					n.cnt = r.cnt + 1'b1;
				end
			end
			ST_SYSRST: begin
				// The request is held a few cycles so slow reset logic sees it.
				if (r.cnt == RST_LAST) begin
					n.state = ST_RUN;
				end else begin
					n.cnt = r.cnt + 1'b1;
				end
				n.wdtPend = 1'b0;
				n.wdtIrq  = 1'b0;
			end
			default: begin
				n.state = ST_RUN;
			end
		endcase

		if (n.state == ST_SYSRST && r.state != ST_SYSRST) begin
			evSet[EV_SYSRST] = 1'b1;
		end
		n.cause  = w1c(r.cause, causeClr, causeSet);
		n.stat   = w1c(r.stat, evClr, evSet);
		n.irq    = |(n.stat & n.mask);
		n.sysRst = (n.state == ST_SYSRST);
		n.halted = inHalt(n.state);

		if (regRd) begin
			case (regAddr)
				OFS_CTRL:    n.rdata = {7'h00, r.halted};
				OFS_WAKE_EN: n.rdata = r.wakeEn;
				OFS_CAUSE:   n.rdata = {4'h0, r.cause};
				OFS_STAT:    n.rdata = {4'h0, r.stat};
				OFS_MASK:    n.rdata = {4'h0, r.mask};
				OFS_PORT_IN: n.rdata = r.portIn;
				default:     n.rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= REGS_RESET;
		end else begin
			r <= n;
		end
	end

	assign regRdata  = r.rdata;
	assign wdtIrqReq = r.wdtIrq;
	assign halted    = r.halted;
	assign sysRstReq = r.sysRst;
	assign irq       = r.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	logic idleHalt;
	assign idleHalt = (r.state == ST_HALT) && !resetPin && !wdtTimeout;

	AST_RECOVERY_FLAG: assert property (
		r.state == ST_RECOVER && r.cnt == REC_LAST && !resetPin
		|=> r.cause[CAUSE_HALT] && r.stat[EV_RECOVERED] && r.state == ST_RUN)
		else $error("recovery end did not set halt flag");

	AST_WDOG_RECOVERS: assert property (
		r.state == ST_HALT && wdtTimeout && !resetPin && !wdtIntMode
		|=> r.state == ST_RECOVER && !sysRstReq && halted)
		else $error("watchdog time-out did not start recovery");

	AST_WDOG_INT_AFTER: assert property (
		r.state == ST_RECOVER && r.cnt == REC_LAST && !resetPin
		&& r.wdtPend && intEnable |=> wdtIrqReq && !halted)
		else $error("watchdog interrupt not presented after recovery");

	AST_WDOG_FLAGS: assert property (
		inHalt(r.state) && r.state != ST_RECOVER && wdtTimeout && !resetPin
		|=> r.cause[CAUSE_WDOG] && r.cause[CAUSE_HALT])
		else $error("watchdog time-out flags not set");

	AST_DISABLED_PIN: assert property (
		idleHalt && pinChg == '0 |=> r.state == ST_HALT)
		else $error("halt left without an enabled wake source");

	AST_PIN_WAKE: assert property (
		idleHalt && pinChg != '0 |=> r.state == ST_FILTER && r.chgPins == $past(pinChg))
		else $error("enabled pin change not taken");

	AST_EXT_RESET: assert property (
		inHalt(r.state) && !extRst_n |=> sysRstReq && r.cause[CAUSE_EXT] && !halted)
		else $error("reset pin did not reset system");

	AST_DEBUG_RESET: assert property (
		inHalt(r.state) && !dbgPin |=> sysRstReq && r.cause[CAUSE_DBG])
		else $error("debug pin low did not reset system");

	AST_SHORT_PULSE: assert property (
		r.state == ST_FILTER && !resetPin && !wdtTimeout
		&& ((portPins ^ r.lastPins) & r.chgPins) == '0
		|=> r.state == ST_HALT && r.cause[CAUSE_HALT])
		else $error("short pulse handled wrongly");

	AST_PORT_FROZEN: assert property (
		r.state != ST_RUN |=> r.state == ST_RUN || $stable(r.portIn))
		else $error("port input data changed while halted");

	// Checks on outputs that the bench only samples now and then.
	logic recEnd;
	assign recEnd = (r.state == ST_RECOVER) && (r.cnt == REC_LAST) && !resetPin;

	AST_FILTER_WAITS: assert property (
		r.state == ST_FILTER && !resetPin && !wdtTimeout && r.cnt != MIN_LAST
		&& ((portPins ^ r.lastPins) & r.chgPins) != '0
		|=> r.state == ST_FILTER && halted)
		else $error("pin filter ended early");

	AST_FILTER_PASSES: assert property (
		r.state == ST_FILTER && !resetPin && !wdtTimeout && r.cnt == MIN_LAST
		&& ((portPins ^ r.lastPins) & r.chgPins) != '0
		|=> r.state == ST_RECOVER && r.cnt == '0)
		else $error("held pin change did not start recovery");

	AST_NO_IRQ_DISABLED: assert property (
		recEnd && !intEnable && !wdtIrqReq |=> !wdtIrqReq)
		else $error("watchdog interrupt presented while interrupts disabled");

	AST_PORT_CAPTURE: assert property (
		recEnd |=> r.portIn == $past(portPins))
		else $error("port input data not loaded at recovery end");

	AST_RUN_TRACKS: assert property (
		r.state == ST_RUN |=> r.portIn == $past(portPins))
		else $error("port input data not following pins in run");

	AST_HALT_ENTRY: assert property (
		r.state == ST_RUN && !resetPin && regWr && regAddr == OFS_CTRL
		&& regWdata[CTRL_HALT_BIT] |=> halted && r.state == ST_HALT)
		else $error("halt request not taken");

	// The length is written out, as a repetition count must be a plain number.
	AST_SYSRST_LEN: assert property (
		$rose(sysRstReq) |-> sysRstReq [*4] ##1 !sysRstReq)
		else $error("system reset request length wrong");

	AST_ACK_CLEARS: assert property (
		wdtIrqAck && !recEnd |=> !wdtIrqReq)
		else $error("interrupt acknowledge did not clear request");

	AST_RDATA_IDLE: assert property (
		!regRd |=> regRdata == '0)
		else $error("read data stood without a read");

	AST_IRQ_LEVEL: assert property (
		irq == |(r.stat & r.mask))
		else $error("interrupt output disagrees with status and mask");

	COV_PIN_RECOVERY: cover property (
		r.state == ST_FILTER ##1 r.state == ST_RECOVER);
	COV_WDOG_INT: cover property ($rose(wdtIrqReq));
	COV_SHORT: cover property ($rose(r.stat[EV_SHORT]));
	COV_SYSRST: cover property (halted ##1 sysRstReq);
	COV_DBG_RESET: cover property (halted && !dbgPin ##1 sysRstReq);

endmodule

`default_nettype wire

// ==== hdl/hws_pkg.sv ====
/*
 * Constants, state encoding and the state record of the halt wake-up sequencer.
 * Assumes one 250 MHz system clock and an 8-pin wake port.
 */
package hws_pkg;

	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 4;
	localparam int          DATA_W         = 8;
	localparam int          PIN_W          = 8;
	localparam int          CNT_W          = 16;
	localparam int          CLK_PERIOD_PS  = 4000;
	localparam int          MIN_WAKE_PS    = 20000;
	localparam int          RECOVERY_PS    = 1000000;
	localparam int          SYSRST_CYC     = 4;
	localparam int          MIN_WAKE_CYC   = (MIN_WAKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          RECOVERY_CYC   = RECOVERY_PS / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0]  OFS_CTRL       = 4'h0;
	localparam logic [3:0]  OFS_WAKE_EN    = 4'h1;
	localparam logic [3:0]  OFS_CAUSE      = 4'h2;
	localparam logic [3:0]  OFS_STAT       = 4'h3;
	localparam logic [3:0]  OFS_MASK       = 4'h4;
	localparam logic [3:0]  OFS_PORT_IN    = 4'h5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          CTRL_HALT_BIT  = 0;
	localparam int          CAUSE_HALT     = 0;
	localparam int          CAUSE_WDOG     = 1;
	localparam int          CAUSE_EXT      = 2;
	localparam int          CAUSE_DBG      = 3;
	localparam int          EV_RECOVERED   = 0;
	localparam int          EV_SYSRST      = 1;
	localparam int          EV_SHORT       = 2;
	localparam int          EV_WDOG        = 3;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_HALT,
		ST_FILTER,
		ST_RECOVER,
		ST_SYSRST
	} hws_state_t;

	typedef struct packed {
		hws_state_t         state;
		logic [CNT_W-1:0]   cnt;
		logic [PIN_W-1:0]   wakeEn;
		logic [3:0]         cause;
		logic [3:0]         stat;
		logic [3:0]         mask;
		logic [PIN_W-1:0]   portIn;
		logic [PIN_W-1:0]   lastPins;
		logic [PIN_W-1:0]   chgPins;
		logic               wdtPend;
		logic               wdtIrq;
		logic               sysRst;
		logic               irq;
		logic               halted;
		logic [DATA_W-1:0]  rdata;
	} hws_regs_t;

	localparam hws_regs_t   REGS_RESET     = '{state: ST_RUN, default: '0};

endpackage

// ==== testbench/hws_pin_model.sv ====
/*
 * Pin-side model: the port pins, the external reset pin and the debug pin.
 * Assumes the bench calls drive() from its own process; pins change after an edge.
 */
`timescale 1ns/1ps
`default_nettype none

module hws_pin_model
	import hws_pkg::*;
(
	// Clock
	input  wire logic             ref_clk,
	// Pins
	output logic      [PIN_W-1:0] portPins,
	output logic                  extRst_n,
	output logic                  dbgPin
);
	// Both reset pins idle high, so an undriven moment never reads as a request.
	initial begin
		portPins = 8'h00;
		extRst_n = 1'b1;
		dbgPin   = 1'b1;
	end

	task automatic drive(input logic [PIN_W-1:0] p, input logic e, input logic d);
		@(posedge ref_clk);
		portPins <= p;
		extRst_n <= e;
		dbgPin   <= d;
	endtask
endmodule

`default_nettype wire

// ==== testbench/test_hws_halt_wakeup.sv ====
/*
 * Self-checking bench of the halt wake-up sequencer: register tasks and
 * wake scenarios. Assumes the pin model above and a short recovery delay.
 */
`timescale 1ns/1ps
`default_nettype none

module test_hws_halt_wakeup;
	import hws_pkg::*;

	logic              ref_clk, arst_n, regWr, regRd;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWdata, regRdata;
	logic              wdtTimeout, wdtIntMode, intEnable, wdtIrqAck;
	logic              wdtIrqReq, halted, sysRstReq, irq, extRst_n, dbgPin;
	logic [PIN_W-1:0]  portPins;
	int                error_cnt = 0;
	int                checks_done = 0;

	hws_halt_wakeup #(.RECOVERY_CYCLES(8)) hws_halt_wakeup_inst (
		.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .wdtTimeout(wdtTimeout), .wdtIntMode(wdtIntMode),
		.intEnable(intEnable), .wdtIrqAck(wdtIrqAck), .wdtIrqReq(wdtIrqReq),
		.halted(halted), .sysRstReq(sysRstReq), .irq(irq),
		.portPins(portPins), .extRst_n(extRst_n), .dbgPin(dbgPin));

	hws_pin_model hws_pin_model_inst (
		.ref_clk(ref_clk), .portPins(portPins), .extRst_n(extRst_n), .dbgPin(dbgPin));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so look right then.
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 chk(regRdata, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wait_run;
		int n;
		n = 0;
		while (halted !== 1'b0 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		#1;
		if (n >= 100) begin
			error_cnt++;
			finish_test();
		end
	endtask

	task automatic clr;
		reg_wr(OFS_CAUSE, 8'hff);
		reg_wr(OFS_STAT, 8'hff);
	endtask

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		arst_n = 1'b0;
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		wdtTimeout = 1'b0;
		wdtIntMode = 1'b0;
		intEnable = 1'b1;
		wdtIrqAck = 1'b0;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 6; a++)
			reg_rd(a[3:0], 8'h00);
		reg_wr(4'hf, 8'hff);
		reg_rd(4'hf, 8'h00);
		reg_wr(OFS_MASK, 8'h0f);
		// Watchdog: reset mode, interrupt mode enabled, interrupt mode disabled.
		for (int m = 0; m < 3; m++) begin
			@(posedge ref_clk);
			wdtIntMode <= (m != 0);
			intEnable <= (m != 2);
			reg_wr(OFS_CTRL, 8'h01);
			#1 chk(halted, 8'h01);
			@(posedge ref_clk);
			wdtTimeout <= 1'b1;
			@(posedge ref_clk);
			wdtTimeout <= 1'b0;
			wait_run();
			chk(wdtIrqReq, (m == 1));
			reg_rd(OFS_CAUSE, 8'h03);
			reg_rd(OFS_STAT, 8'h09);
			tick(1);
			chk(irq, 8'h01);
			@(posedge ref_clk);
			wdtIrqAck <= 1'b1;
			@(posedge ref_clk);
			wdtIrqAck <= 1'b0;
			tick(1);
			chk(wdtIrqReq, 8'h00);
			reg_wr(OFS_MASK, 8'h00);
			tick(1);
			chk(irq, 8'h00);
			reg_wr(OFS_MASK, 8'h0f);
			clr();
			tick(1);
			chk(irq, 8'h00);
		end
		// Port wake: disabled pin ignored, then a rise and a fall on pin 2.
		reg_wr(OFS_WAKE_EN, 8'h04);
		reg_wr(OFS_CTRL, 8'h01);
		hws_pin_model_inst.drive(8'h01, 1'b1, 1'b1);
		tick(20);
		chk(halted, 8'h01);
		hws_pin_model_inst.drive(8'h05, 1'b1, 1'b1);
		reg_rd(OFS_PORT_IN, 8'h00);
		wait_run();
		reg_rd(OFS_PORT_IN, 8'h05);
		reg_rd(OFS_CAUSE, 8'h01);
		clr();
		reg_wr(OFS_CTRL, 8'h01);
		hws_pin_model_inst.drive(8'h01, 1'b1, 1'b1);
		wait_run();
		reg_rd(OFS_CAUSE, 8'h01);
		reg_rd(OFS_PORT_IN, 8'h01);
		clr();
		// Pulse of two cycles is shorter than the filter.
		reg_wr(OFS_CTRL, 8'h01);
		hws_pin_model_inst.drive(8'h05, 1'b1, 1'b1);
		@(posedge ref_clk);
		hws_pin_model_inst.drive(8'h01, 1'b1, 1'b1);
		tick(20);
		chk(halted, 8'h01);
		reg_rd(OFS_CAUSE, 8'h01);
		reg_rd(OFS_STAT, 8'h04);
		reg_rd(OFS_PORT_IN, 8'h01);
		clr();
		// Debug pin low, then external reset pin, while halted.
		for (int k = 0; k < 2; k++) begin
			hws_pin_model_inst.drive(8'h01, ~k[0], k[0]);
			tick(2);
			chk(sysRstReq, 8'h01);
			hws_pin_model_inst.drive(8'h01, 1'b1, 1'b1);
			wait_run();
			tick(6);
			chk(sysRstReq, 8'h00);
			reg_rd(OFS_CAUSE, k ? 8'h04 : 8'h08);
			reg_rd(OFS_STAT, 8'h02);
			clr();
			reg_wr(OFS_CTRL, 8'h01);
		end
		finish_test();
	end
endmodule

`default_nettype wire
